// ==== design/hub_strap_regs.vh ====
// constants for the strap-selected hub mode and descriptor store
`ifndef HUB_STRAP_REGS_VH
`define HUB_STRAP_REGS_VH

// register offsets (byte addresses)
`define REG_STRAP_STATUS   8'h00
`define REG_IDENT          8'h04
`define REG_DESC_CTRL      8'h08
`define REG_DESC_STATUS    8'h0C

// status field positions
`define ST_SELF_BIT        0
`define ST_GANG_BIT        1
`define ST_PORTS_LSB       2
`define ST_LATCHED_BIT     8
`define DS_BUSY_BIT        8

// reset values
`define DESC_CTRL_RST      1'b1
`define VENDOR_RST         16'h0F0F
`define PRODUCT_RST        16'h0A0A

// mode codes
`define MODE_SELF_IND      2'h0
`define MODE_BUS_IND       2'h1
`define MODE_BUS_GANG      2'h2

// descriptor sizes
`define DEV_DESC_LEN       16'h0012
`define CFG_TOTAL_LEN      16'h0019
`define CFG_DESC_LEN       8'h09
`define IF_DESC_LEN        8'h09
`define EP_DESC_LEN        8'h07
`define IF_START           5'h09
`define EP_START           5'h12

// descriptor contents
`define TYPE_DEVICE        8'h01
`define TYPE_CONFIG        8'h02
`define TYPE_INTERFACE     8'h04
`define TYPE_ENDPOINT      8'h05
`define USB_RELEASE        16'h0100
`define DEVICE_RELEASE     16'h0100
`define HUB_CLASS          8'h09
`define EP0_MAX_PKT        8'h08
`define NUM_CONFIGS        8'h01
`define NUM_INTERFACES     8'h01
`define CONFIG_VALUE       8'h01
`define NUM_ENDPOINTS      8'h01
`define ATTR_SELF          8'h60
`define ATTR_BUS           8'hA0
`define POWER_SELF         8'h01
`define POWER_BUS          8'hFA
`define EP_ADDRESS         8'h81
`define EP_ATTR_INTR       8'h03
`define EP_MAX_PKT         16'h0001
`define EP_INTERVAL        8'hEF

`endif

// ==== design/hub_desc_rom.v ====
// descriptor byte store: device, configuration, interface, endpoint
`timescale 1ns/1ns
`include "hub_strap_regs.vh"

module hub_desc_rom (
    input  wire        cfgKind,      // 0 device, 1 configuration set
    input  wire [4:0]  byteIdx,      // offset within the chosen set
    input  wire        selfPowered,  // latched power mode
    input  wire [15:0] vendorId,     // identity words, low byte first
    input  wire [15:0] productId,
    output reg  [7:0]  romByte
);

    // full-width copies, so single bytes can be taken from them
    localparam [15:0] DEV_LEN = `DEV_DESC_LEN;
    localparam [15:0] USB_REL = `USB_RELEASE;
    localparam [15:0] DEV_REL = `DEVICE_RELEASE;
    localparam [15:0] CFG_TOT = `CFG_TOTAL_LEN;
    localparam [15:0] EP_PKT  = `EP_MAX_PKT;

    // one byte per offset, little-endian word fields
    always @* begin
        romByte = 8'h00;                           // unused offsets and string indices read zero
        if (!cfgKind) begin
            case (byteIdx)
                5'h00: romByte = DEV_LEN[7:0];
                5'h01: romByte = `TYPE_DEVICE;
                5'h02: romByte = USB_REL[7:0];
                5'h03: romByte = USB_REL[15:8];
                5'h04: romByte = `HUB_CLASS;
                5'h07: romByte = `EP0_MAX_PKT;
                5'h08: romByte = vendorId[7:0];
                5'h09: romByte = vendorId[15:8];
                5'h0A: romByte = productId[7:0];
                5'h0B: romByte = productId[15:8];
                5'h0C: romByte = DEV_REL[7:0];
                5'h0D: romByte = DEV_REL[15:8];
                5'h11: romByte = `NUM_CONFIGS;
                default: romByte = 8'h00;                          // subclass, protocol, strings
            endcase
        end else begin
            case (byteIdx)
                5'h00: romByte = `CFG_DESC_LEN;
                5'h01: romByte = `TYPE_CONFIG;
                5'h02: romByte = CFG_TOT[7:0];
                5'h03: romByte = CFG_TOT[15:8];
                5'h04: romByte = `NUM_INTERFACES;
                5'h05: romByte = `CONFIG_VALUE;
                5'h07: romByte = selfPowered ? `ATTR_SELF : `ATTR_BUS;
                5'h08: romByte = selfPowered ? `POWER_SELF : `POWER_BUS;
                5'h09: romByte = `IF_DESC_LEN;
                5'h0A: romByte = `TYPE_INTERFACE;
                5'h0D: romByte = `NUM_ENDPOINTS;
                5'h0E: romByte = `HUB_CLASS;
                5'h12: romByte = `EP_DESC_LEN;
                5'h13: romByte = `TYPE_ENDPOINT;
                5'h14: romByte = `EP_ADDRESS;
                5'h15: romByte = `EP_ATTR_INTR;
                5'h16: romByte = EP_PKT[7:0];
                5'h17: romByte = EP_PKT[15:8];
                5'h18: romByte = `EP_INTERVAL;
                default: romByte = 8'h00;                          // zero fields and indices
            endcase
        end
    end

endmodule

// ==== design/hub_strap_desc.v ====
// strap mode latch, port pin steering and descriptor streaming for endpoint 0
`timescale 1ns/1ns
`include "hub_strap_regs.vh"

module hub_strap_desc #(
    parameter [15:0] VENDOR_ID  = `VENDOR_RST,   // arbitrary value, not a real assignment
    parameter [15:0] PRODUCT_ID = `PRODUCT_RST   // arbitrary value, not a real assignment
) (
    input  wire        core_clk,
    input  wire        rst_n,
    // strap and port pins
    input  wire        port5_dplus_sel_hi,
    input  wire        port5_dminus_sel_lo,
    input  wire        port5_overcurrent_gang_strap,
    input  wire [3:0]  portOvercurrentN,     // ports 1..4, bit 0 is port1_overcurrent_n
    input  wire [4:0]  portPowerReq,         // per-port power request from the controller
    output reg  [4:0]  portPowerSwitch,      // bit 0 is port1_power_switch, bit 4 port5_power_switch
    output reg  [4:0]  portOvercurrent,      // active-high overcurrent seen per port
    output reg         port5DataEnable,      // port 5 data pins belong to the repeater
    output reg         selfPowered,
    output reg         gangedPower,
    output reg  [2:0]  portCount,
    // endpoint 0 descriptor port
    input  wire        descReqStart,         // one-cycle request pulse
    input  wire        descReqConfig,        // 0 device, 1 configuration set
    input  wire [15:0] descReqLength,        // host wLength
    input  wire        descReady,            // handler takes the byte on offer
    output reg         descValid,
    output reg  [7:0]  descByte,
    output reg         descLast,
    output reg         descRefused,          // one-cycle pulse: request ignored
    // register port
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWdata,
    input  wire        regWrite,
    input  wire        regRead,
    output reg  [31:0] regRdata
);

    // stream states
    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;

    // smaller of requested and available length, clipped to the index width
    function [4:0] clipLength;
        input [15:0] want;
        input [15:0] avail;
        begin
            if (want < avail) begin
                clipLength = want[4:0];
            end else begin
                clipLength = avail[4:0];
            end
        end
    endfunction

    reg        latched_r;        // straps taken since reset
    reg [1:0]  mode_r;           // latched operating mode
    reg [15:0] vendor_r;         // identity words, software may replace
    reg [15:0] product_r;
    reg        descEnable_r;     // zero makes every request refused
    reg        state_r;
    reg        kind_r;           // set being streamed
    reg [4:0]  idx_r;            // next byte offset
    reg [4:0]  limit_r;          // bytes in this answer
    reg [4:0]  lastLen_r;        // length of the last answer
    reg [1:0]  mode_nxt;
    wire [7:0] romByte;
    wire       modeSelf;
    wire       modeGang;
    wire       offerFree;
    wire [4:0] reqLimit;

    assign modeSelf  = (mode_r == `MODE_SELF_IND);
    assign modeGang  = (mode_r == `MODE_BUS_GANG);
    // a new byte may be offered when none waits or the waiting one is taken
    assign offerFree = !descValid || descReady;
    assign reqLimit  = descReqConfig ? clipLength(descReqLength, `CFG_TOTAL_LEN)
                                     : clipLength(descReqLength, `DEV_DESC_LEN);

    // decode the strap levels into a mode
    always @* begin
        mode_nxt = `MODE_SELF_IND;
        if (!port5_dplus_sel_hi && port5_dminus_sel_lo) begin
            if (port5_overcurrent_gang_strap) begin
                mode_nxt = `MODE_BUS_IND;
            end else begin
                mode_nxt = `MODE_BUS_GANG;
            end
        end
        // select-hi high has no defined mode; it falls back to self-powered
    end

    // latch the straps at the first edge after reset release, never again
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_r <= 1'b0;
            mode_r    <= `MODE_SELF_IND;
        end else if (!latched_r) begin
            latched_r <= 1'b1;
            mode_r    <= mode_nxt;
        end
    end

    // port pin steering per mode, registered so outputs come from flops
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            portPowerSwitch <= 5'h00;                           // ports unpowered in reset
            portOvercurrent <= 5'h00;
            port5DataEnable <= 1'b0;
            selfPowered     <= 1'b0;
            gangedPower     <= 1'b0;
            portCount       <= 3'h0;
        end else if (!latched_r) begin
            // mode not known yet: keep everything off
            portPowerSwitch <= 5'h00;
            portOvercurrent <= 5'h00;
            port5DataEnable <= 1'b0;
            selfPowered     <= 1'b0;
            gangedPower     <= 1'b0;
            portCount       <= 3'h0;
        end else begin
            selfPowered <= modeSelf;
            gangedPower <= modeGang;
            case (mode_r)
                `MODE_SELF_IND: begin
                    // five ports, port 5 pins become data and overcurrent
                    portPowerSwitch <= portPowerReq;
                    portOvercurrent <= {!port5_overcurrent_gang_strap, ~portOvercurrentN};
                    port5DataEnable <= 1'b1;
                    portCount       <= 3'h5;
                end
                `MODE_BUS_IND: begin
                    // four ports; port 5 pins and its switch are left alone
                    portPowerSwitch <= {1'b0, portPowerReq[3:0]};
                    portOvercurrent <= {1'b0, ~portOvercurrentN};
                    port5DataEnable <= 1'b0;
                    portCount       <= 3'h4;
                end
                `MODE_BUS_GANG: begin
                    // one switch and one sense pin serve all four ports
                    portPowerSwitch <= {4'h0, |portPowerReq[3:0]};
                    portOvercurrent <= {1'b0, {4{!portOvercurrentN[0]}}};
                    port5DataEnable <= 1'b0;
                    portCount       <= 3'h4;
                end
                default: begin
                    portPowerSwitch <= 5'h00;
                    portOvercurrent <= 5'h00;
                    port5DataEnable <= 1'b0;
                    portCount       <= 3'h0;
                end
            endcase
        end
    end

    // byte store lookup at the current offset
    hub_desc_rom uRom (
        .cfgKind     (kind_r),
        .byteIdx     (idx_r),
        .selfPowered (modeSelf),
        .vendorId    (vendor_r),
        .productId   (product_r),
        .romByte     (romByte)
    );

    // descriptor stream: one byte per cycle while the handler keeps taking
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r     <= ST_IDLE;
            kind_r      <= 1'b0;
            idx_r       <= 5'h00;
            limit_r     <= 5'h00;
            lastLen_r   <= 5'h00;
            descValid   <= 1'b0;
            descByte    <= 8'h00;
            descLast    <= 1'b0;
            descRefused <= 1'b0;
        end else begin
            descRefused <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (descReady && descValid) begin
                        descValid <= 1'b0;              // final byte taken
                        descLast  <= 1'b0;
                    end
                    if (descReqStart) begin
                        if (!descEnable_r || !latched_r || descValid) begin
                            // disabled, mode unknown, or previous byte still held
                            descRefused <= 1'b1;
                        end else if (reqLimit == 5'h00) begin
                            lastLen_r <= 5'h00;         // zero-length request, nothing sent
                        end else begin
                            kind_r    <= descReqConfig;
                            idx_r     <= 5'h00;
                            limit_r   <= reqLimit;
                            lastLen_r <= reqLimit;
                            state_r   <= ST_SEND;
                        end
                    end
                end
                ST_SEND: begin
                    // requests during a stream are dropped, not queued
                    if (descReqStart) begin
                        descRefused <= 1'b1;
                    end
                    if (offerFree) begin
                        descValid <= 1'b1;
                        descByte  <= romByte;
                        descLast  <= (idx_r == limit_r - 5'h01);
                        idx_r     <= idx_r + 5'h01;     // sets run back to back
                        if (idx_r == limit_r - 5'h01) begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // register writes: identity words and the enable bit
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            vendor_r     <= VENDOR_ID;
            product_r    <= PRODUCT_ID;
            descEnable_r <= `DESC_CTRL_RST;
        end else if (regWrite) begin
            case (regAddr)
                `REG_IDENT: begin
                    // changing identity mid-stream would tear the answer
                    vendor_r  <= regWdata[15:0];
                    product_r <= regWdata[31:16];
                end
                `REG_DESC_CTRL: begin
                    descEnable_r <= regWdata[0];
                end
                default: begin
                    vendor_r <= vendor_r;       // read-only or unmapped: ignored
                end
            endcase
        end
    end

    // register reads: data stand in the cycle after the strobe only
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 32'h00000000;
        end else if (regRead) begin
            case (regAddr)
                `REG_STRAP_STATUS: begin
                    regRdata <= {23'h000000, latched_r, 3'h0, portCount, gangedPower, selfPowered};
                end
                `REG_IDENT: begin
                    regRdata <= {product_r, vendor_r};
                end
                `REG_DESC_CTRL: begin
                    regRdata <= {31'h00000000, descEnable_r};
                end
                `REG_DESC_STATUS: begin
                    regRdata <= {23'h000000, state_r, 3'h0, lastLen_r};
                end
                default: begin
                    regRdata <= 32'h00000000;   // unmapped reads zero
                end
            endcase
        end else begin
            regRdata <= 32'h00000000;
        end
    end

endmodule

// ==== dv/hub_strap_desc_sva.sv ====
// checker for mode latch, port steering and descriptor streaming
`timescale 1ns/1ns
module hub_strap_desc_sva (
    input wire       core_clk,
    input wire       rst_n,
    input wire [3:0] portOvercurrentN,
    input wire [4:0] portPowerReq,
    input wire [4:0] portPowerSwitch,
    input wire [4:0] portOvercurrent,
    input wire       port5DataEnable,
    input wire       selfPowered,
    input wire       gangedPower,
    input wire [2:0] portCount,
    input wire       descReqStart,
    input wire       descReady,
    input wire       descValid,
    input wire [7:0] descByte,
    input wire       descLast,
    input wire       descRefused
);
    // one clock domain, so one clocking and one disable
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    AST_SELF_MODE: assert property (selfPowered |-> port5DataEnable && portCount == 3'h5 && !gangedPower)
        else $error("self mode outputs wrong");
    AST_BUS_PORT5: assert property (!selfPowered && portCount != 3'h0
        |-> !portPowerSwitch[4] && !portOvercurrent[4] && !port5DataEnable)
        else $error("port 5 active in bus mode");
    AST_GANG_MODE: assert property (gangedPower |-> portCount == 3'h4 && !selfPowered)
        else $error("ganged mode outputs wrong");
    AST_GANG_SWITCH: assert property (gangedPower && $past(gangedPower)
        |-> portPowerSwitch[0] == (|$past(portPowerReq[3:0])))
        else $error("ganged switch not the or of requests");
    AST_GANG_OVC: assert property (gangedPower && $past(gangedPower)
        |-> portOvercurrent[3:0] == {4{!$past(portOvercurrentN[0])}})
        else $error("ganged overcurrent not mirrored");
    // mode never moves once latched, whatever the pins do
    AST_MODE_HELD: assert property ($past(portCount) != 3'h0
        |-> $stable(portCount) && $stable(selfPowered) && $stable(gangedPower))
        else $error("mode changed after latch");
    AST_BYTE_HOLD: assert property (descValid && !descReady |=> descValid && $stable(descByte) && $stable(descLast))
        else $error("offered byte not held");
    AST_FIRST_BYTE: assert property ($rose(descValid) |-> descByte == 8'h12 || descByte == 8'h09)
        else $error("first byte is not a length");
    AST_BUSY_REFUSE: assert property (descReqStart && descValid |=> descRefused)
        else $error("start while busy not refused");
    AST_LAST_DROP: assert property (descValid && descReady && descLast |=> !descValid)
        else $error("valid after last byte");
endmodule

bind hub_strap_desc hub_strap_desc_sva u_sva (.core_clk(core_clk), .rst_n(rst_n),
    .portOvercurrentN(portOvercurrentN), .portPowerReq(portPowerReq), .portPowerSwitch(portPowerSwitch),
    .portOvercurrent(portOvercurrent), .port5DataEnable(port5DataEnable), .selfPowered(selfPowered),
    .gangedPower(gangedPower), .portCount(portCount), .descReqStart(descReqStart), .descReady(descReady),
    .descValid(descValid), .descByte(descByte), .descLast(descLast), .descRefused(descRefused));

// ==== dv/hub_ep0_host.sv ====
// endpoint 0 handler model that takes descriptor bytes
`timescale 1ns/1ns
module hub_ep0_host (
    input  wire       core_clk,
    input  wire       rst_n,
    input  wire       slow,
    input  wire       clr,
    input  wire       descValid,
    input  wire [7:0] descByte,
    input  wire       descLast,
    output reg        descReady
);
    reg [7:0] capBuf [0:63]; // bytes in arrival order
    integer   capN;          // bytes taken
    reg       capDone;       // final byte taken
    reg [2:0] pace;          // stall pattern, ready one cycle in eight
    // a byte counts only at an edge with valid and ready both high
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            capN <= 0;
            capDone <= 1'b0;
            pace <= 3'h0;
            descReady <= 1'b0;
        end else begin
            pace <= pace + 3'h1;
            descReady <= !slow || pace == 3'h5;
            if (clr) begin
                capN <= 0;
                capDone <= 1'b0;
            end else if (descValid && descReady) begin
                capBuf[capN[5:0]] <= descByte;
                capN <= capN + 1;
                if (descLast)
                    capDone <= 1'b1;
            end
        end
    end
endmodule

// ==== dv/tb.sv ====
// bench: strap modes, port steering, descriptors, registers
`timescale 1ns/1ns
`include "hub_strap_regs.vh"
module tb;
    localparam [15:0] VID = `VENDOR_RST;
    localparam [15:0] PID = `PRODUCT_RST;
    reg         core_clk;
    reg         rst_n = 1'b0;
    reg         selHi = 1'b0, selLo = 1'b0, gangPin = 1'b0; // straps, later port 5 pins
    reg  [3:0]  ocN = 4'hF;            // low active overcurrent
    reg  [4:0]  pwrReq = 5'h00;
    reg         reqStart = 1'b0, reqCfg = 1'b0;
    reg  [15:0] reqLen = 16'h0000;
    reg  [7:0]  regAddr = 8'h00;
    reg  [31:0] regWdata = 32'h00000000;
    reg         regWrite = 1'b0, regRead = 1'b0;
    reg         hostSlow = 1'b0, hostClr = 1'b0;
    reg         curSelf;                // mode the bench expects
    wire [4:0]  pwrSw, ovc;
    wire        p5En, selfPw, ganged, descReady, descValid, descLast, descRefused;
    wire [2:0]  cnt;
    wire [7:0]  descByte;
    wire [31:0] regRdata;
    integer     err_count = 0;
    integer     checked = 0;
    integer     cycles = 0;
    integer     m, i;
    reg  [31:0] seed = 32'h1B58;
    reg  [31:0] rd;

    hub_strap_desc dut (.core_clk(core_clk), .rst_n(rst_n), .port5_dplus_sel_hi(selHi),
        .port5_dminus_sel_lo(selLo), .port5_overcurrent_gang_strap(gangPin), .portOvercurrentN(ocN),
        .portPowerReq(pwrReq), .portPowerSwitch(pwrSw), .portOvercurrent(ovc), .port5DataEnable(p5En),
        .selfPowered(selfPw), .gangedPower(ganged), .portCount(cnt), .descReqStart(reqStart),
        .descReqConfig(reqCfg), .descReqLength(reqLen), .descReady(descReady), .descValid(descValid),
        .descByte(descByte), .descLast(descLast), .descRefused(descRefused), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
    hub_ep0_host host (.core_clk(core_clk), .rst_n(rst_n), .slow(hostSlow), .clr(hostClr),
        .descValid(descValid), .descByte(descByte), .descLast(descLast), .descReady(descReady));

    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // hang guard, far above the few thousand cycles needed
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            summarize;
        end
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected byte, words little-endian
    function [7:0] expByte(input c, input [4:0] k, input s);
        reg [143:0] d;
        reg [199:0] t;
        begin
            d = {32'h12010001, 32'h09000008, VID[7:0], VID[15:8], PID[7:0], PID[15:8], 48'h000100000001};
            t = {56'h09021900010100, s ? 16'h6001 : 16'hA0FA, 72'h090400000109000000, 56'h070581030100EF};
            expByte = c ? t[199 - 8 * k -: 8] : d[143 - 8 * k -: 8];
        end
    endfunction
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("ERROR %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", checked, err_count);
            if (err_count == 0 && checked > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task regWr(input [7:0] a, input [31:0] d);
        begin
            @(posedge core_clk);
            regAddr <= a;
            regWdata <= d;
            regWrite <= 1'b1;
            @(posedge core_clk);
            regWrite <= 1'b0;
        end
    endtask
    // read data stands only in the cycle after the strobe
    task regRd(input [7:0] a);
        begin
            @(posedge core_clk);
            regAddr <= a;
            regRead <= 1'b1;
            @(posedge core_clk);
            regRead <= 1'b0;
            #1 rd = regRdata;
        end
    endtask
    // straps held through reset, sampled at the first edge after release
    task doReset(input h, input l, input g);
        begin
            @(posedge core_clk);
            rst_n <= 1'b0;
            selHi <= h;
            selLo <= l;
            gangPin <= g;
            repeat (2) @(posedge core_clk);
            rst_n <= 1'b1;
            #1 chk("countInReset", cnt, 0);
            repeat (3) @(posedge core_clk);
        end
    endtask
    // pins toggled at random after latch; steering must follow the mode
    task modeChk(input integer md);
        reg s;
        reg g;
        reg [2:0] n;
        begin
            s = md == 0;
            g = md == 2;
            n = s ? 3'h5 : 3'h4;
            regRd(`REG_STRAP_STATUS);
            chk("status", rd, {23'h0, 1'b1, 3'h0, n, g, s});
            for (i = 0; i < 8; i = i + 1) begin
                seed = lfsr(seed);
                @(posedge core_clk);
                pwrReq <= seed[4:0];
                ocN <= seed[8:5];
                gangPin <= seed[9];
                selHi <= seed[10];
                selLo <= seed[11];
                repeat (2) @(posedge core_clk);
                #1 chk("mode", {p5En, selfPw, ganged, cnt}, {s, s, g, n});
                if (g) begin
                    chk("gangSwitch", pwrSw, {4'h0, |seed[3:0]});
                    chk("gangOvc", ovc, {1'b0, {4{~seed[5]}}});
                end else begin
                    chk("switch", pwrSw, {seed[4] & s, seed[3:0]});
                    chk("ovc", ovc, {~seed[9] & s, ~seed[8:5]});
                end
            end
            $display("mode %0d test done", md);
        end
    endtask
    // one request; slow host with more than two bytes due also gets a start while a byte waits
    task getDesc(input c, input [15:0] len, input slow);
        integer n;
        integer t;
        begin
            n = c ? 25 : 18;
            if (len < n)
                n = len;
            @(posedge core_clk);
            hostSlow <= slow;
            hostClr <= 1'b1;
            reqStart <= 1'b1;
            reqCfg <= c;
            reqLen <= len;
            @(posedge core_clk);
            hostClr <= 1'b0;
            reqStart <= 1'b0;
            #1 chk("accepted", descRefused, 0);
            if (slow && n > 2) begin
                @(posedge core_clk);
                reqStart <= 1'b1;
                @(posedge core_clk);
                reqStart <= 1'b0;
                #1 chk("busyRefused", descRefused, 1);
            end
            t = 0;
            while (host.capDone !== 1'b1 && t < 400 && n > 0) begin
                @(posedge core_clk);
                #1 t = t + 1;
            end
            repeat (4) @(posedge core_clk);
            #1 chk("count", host.capN, n);
            for (t = 0; t < n; t = t + 1)
                chk("descByte", host.capBuf[t], expByte(c, t[4:0], curSelf));
            $display("descriptor test done, %0d bytes", n);
        end
    endtask

    // main sequence
    initial begin
        for (m = 0; m < 3; m = m + 1) begin
            curSelf = m == 0;
            doReset(1'b0, m != 0, m == 1);
            modeChk(m);
            getDesc(1'b1, 16'h0019, m == 1);
        end
        getDesc(1'b0, 16'h0012, 1'b0);
        getDesc(1'b0, 16'h0001, 1'b0);
        getDesc(1'b0, 16'h0040, 1'b1);
        getDesc(1'b1, 16'h0000, 1'b0);
        getDesc(1'b1, 16'hFFFF, 1'b1);
        for (i = 0; i < 6; i = i + 1) begin
            seed = lfsr(seed);
            getDesc(seed[8], {10'h0, seed[5:0]}, seed[9]);
        end
        getDesc(1'b1, 16'h000A, 1'b0);
        regRd(`REG_DESC_STATUS);
        chk("lastLen", rd, 32'h0000000A);
        regRd(`REG_IDENT);
        chk("ident", rd, {PID, VID});
        regRd(`REG_DESC_CTRL);
        chk("ctrl", rd, 32'h00000001);
        regRd(8'h10);
        chk("unmapped", rd, 32'h00000000);
        regWr(`REG_STRAP_STATUS, 32'hFFFFFFFF);
        regRd(`REG_STRAP_STATUS);
        chk("statusRo", rd, 32'h00000112);
        // answers switched off: a start is refused and nothing streams
        regWr(`REG_DESC_CTRL, 32'h00000000);
        @(posedge core_clk);
        reqStart <= 1'b1;
        reqCfg <= 1'b0;
        reqLen <= 16'h0012;
        @(posedge core_clk);
        reqStart <= 1'b0;
        #1 chk("offRefused", descRefused, 1);
        repeat (3) @(posedge core_clk);
        #1 chk("offIdle", descValid, 0);
        regWr(`REG_DESC_CTRL, 32'h00000001);
        seed = lfsr(seed);
        regWr(`REG_IDENT, seed);
        regRd(`REG_IDENT);
        chk("identRw", rd, seed);
        $display("register test done");
        summarize;
    end
endmodule
